// *** inc/fgscp_pkg.sv ***
// constants and types for the filter gain serial configuration port
package fgscp_pkg;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned FREQ_W = 5;
  localparam int unsigned BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] DATA_BITS = 4'h8;
  // field placement, frequency code low, selections above it
  localparam int unsigned FREQ_LSB = 0;
  localparam int unsigned PREAMP_POS = 5;
  localparam int unsigned VGA_MAX_POS = 6;
  localparam int unsigned POSTAMP_POS = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [BIT_CNT_W-1:0] CNT_RESET = 4'h0;
  localparam logic [FREQ_W-1:0] FREQ_NO_SIGNAL = 5'h00;
  typedef enum logic [1:0] {FGSCP_IDLE, FGSCP_CMD, FGSCP_WRITE, FGSCP_READ} fgscp_state_t;
endpackage

// *** rtl/fgscp_port.sv ***
// serial configuration port holding the shared filter and gain control word
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - one eight-bit word holds a five-bit corner code and three gain selection bits.
// - the single word drives both channels at once, with no per-channel copy.
// - the first rising serial clock after the frame falls samples data: high writes, low reads.
// - a write captures eight bits on the next eight rising edges, least significant first.
// - the captured code is applied only when the frame line returns high after a write.
// - a read shifts the stored word out, least significant first, on eight falling edges.
// - a read ends when the frame goes high and leaves the stored word unchanged.
// - the read returns the codes last written.
// - the preamplifier bit selects 3 dB or 6 dB for both input buffers together.
// - the postamplifier bit selects one of two fixed gains.
// - a high offset-loop disable input turns the offset loop off, otherwise it stays on.
// - corner code N gives N MHz for 1 to 31; code 0 passes no signal.
module fgscp_port
  import fgscp_pkg::*;
#(
  parameter int unsigned P_FREQ_LSB = fgscp_pkg::FREQ_LSB,
  parameter int unsigned P_PREAMP_POS = fgscp_pkg::PREAMP_POS,
  parameter int unsigned P_VGA_MAX_POS = fgscp_pkg::VGA_MAX_POS,
  parameter int unsigned P_POSTAMP_POS = fgscp_pkg::POSTAMP_POS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic latch_frame_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic offset_loop_disable,
  output logic serial_out,
  output logic serial_out_en,
  output logic [fgscp_pkg::FREQ_W-1:0] corner_code,
  output logic signal_pass,
  output logic preamp_gain_6db,
  output logic vga_max_gain_sel,
  output logic postamp_gain_sel,
  output logic offset_loop_enable
);
  import fgscp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage is read only by the second
  logic [2:0] le_s1_r, le_s2_r;
  logic sclk_d_r, le_d_r;
  // reset matches the idle pins (frame high, clock low) so no false edge follows reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      le_s1_r <= 3'h4;
      le_s2_r <= 3'h4;
    end else begin
      le_s1_r <= {latch_frame_n, serial_clk, serial_data};
      le_s2_r <= le_s1_r;
    end
  end

  // static strap pin still gets two stages before the output flop
  logic ofd_s1_r, ofd_s2_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ofd_s1_r <= 1'b0;
      ofd_s2_r <= 1'b0;
    end else begin
      ofd_s1_r <= offset_loop_disable;
      ofd_s2_r <= ofd_s1_r;
    end
  end

  logic frame_n_s, sclk_s, sdata_s;
  assign frame_n_s = le_s2_r[2];
  assign sclk_s = le_s2_r[1];
  assign sdata_s = le_s2_r[0];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_d_r <= 1'b0;
      le_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      le_d_r <= frame_n_s;
    end
  end

  logic sclk_rise, sclk_fall, frame_rise;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign frame_rise = frame_n_s & ~le_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // transaction sequencer
  fgscp_state_t state_r;
  logic [BIT_CNT_W-1:0] cnt_r;
  logic [CTRL_W-1:0] shift_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] rd_r;
  logic wr_done_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= FGSCP_IDLE;
    end else if (frame_n_s) begin
      state_r <= FGSCP_IDLE;
    end else begin
      case (state_r)
        FGSCP_IDLE: state_r <= FGSCP_CMD;
        FGSCP_CMD: begin
          if (sclk_rise) begin
            state_r <= sdata_s ? FGSCP_WRITE : FGSCP_READ;
          end
        end
        FGSCP_WRITE: state_r <= FGSCP_WRITE;
        FGSCP_READ: state_r <= FGSCP_READ;
        default: state_r <= FGSCP_IDLE;
      endcase
    end
  end

  // bit counter shared by both directions; extra edges past eight are ignored
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= CNT_RESET;
    end else if (state_r == FGSCP_CMD || frame_n_s) begin
      cnt_r <= CNT_RESET;
    end else if (cnt_r != DATA_BITS &&
                 ((state_r == FGSCP_WRITE && sclk_rise) ||
                  (state_r == FGSCP_READ && sclk_fall))) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // write shift register, lsb arrives first so shift right from the top
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shift_r <= CTRL_RESET;
    end else if (state_r == FGSCP_WRITE && sclk_rise && cnt_r != DATA_BITS) begin
      shift_r <= {sdata_s, shift_r[CTRL_W-1:1]};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_done_r <= 1'b0;
    end else if (frame_n_s) begin
      wr_done_r <= 1'b0;
    end else if (state_r == FGSCP_WRITE && sclk_rise && cnt_r == DATA_BITS - 4'h1) begin
      wr_done_r <= 1'b1;
    end
  end

  // partial writes are dropped so a short frame cannot corrupt the word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= CTRL_RESET;
    end else if (frame_rise && wr_done_r) begin
      ctrl_r <= shift_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // readback: load on command, present next bit on each of the first eight falling edges
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_r <= CTRL_RESET;
    end else if (state_r == FGSCP_CMD) begin
      rd_r <= ctrl_r;
    end else if (state_r == FGSCP_READ && sclk_fall && cnt_r != DATA_BITS) begin
      rd_r <= {1'b0, rd_r[CTRL_W-1:1]};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
    end else if (state_r == FGSCP_READ && sclk_fall && cnt_r != DATA_BITS) begin
      serial_out <= rd_r[0];
      serial_out_en <= 1'b1;
    end else if (frame_n_s) begin
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared analog controls, one copy feeds both channels
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      corner_code <= FREQ_NO_SIGNAL;
      signal_pass <= 1'b0;
      preamp_gain_6db <= 1'b0;
      vga_max_gain_sel <= 1'b0;
      postamp_gain_sel <= 1'b0;
      offset_loop_enable <= 1'b1;
    end else begin
      corner_code <= ctrl_r[P_FREQ_LSB +: FREQ_W];
      signal_pass <= ctrl_r[P_FREQ_LSB +: FREQ_W] != FREQ_NO_SIGNAL;
      preamp_gain_6db <= ctrl_r[P_PREAMP_POS];
      vga_max_gain_sel <= ctrl_r[P_VGA_MAX_POS];
      postamp_gain_sel <= ctrl_r[P_POSTAMP_POS];
      offset_loop_enable <= ~ofd_s2_r;
    end
  end
endmodule
`default_nettype wire

// *** verification/fgscp_port_assertions.sv ***
// checker for the serial port
`timescale 1ns/1ns
`default_nettype none
module fgscp_port_assertions
  import fgscp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic latch_frame_n,
  input wire logic serial_clk,
  input wire logic offset_loop_disable,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic [fgscp_pkg::FREQ_W-1:0] corner_code,
  input wire logic signal_pass,
  input wire logic preamp_gain_6db,
  input wire logic vga_max_gain_sel,
  input wire logic postamp_gain_sel,
  input wire logic offset_loop_enable
);
  wire logic [7:0] w = {postamp_gain_sel, vga_max_gain_sel, preamp_gain_6db, corner_code};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_RST: assert property ($fell(reset) |-> w == CTRL_RESET) else $error("rst");
  AST_OLE: assert property (offset_loop_enable ^ $past(offset_loop_disable, 3))
    else $error("ole");
  AST_PASS: assert property (signal_pass == (corner_code != 0)) else $error("pass");
  // margin covers sync plus update latency
  AST_HOLD: assert property (!latch_frame_n [*8] |-> $stable(w)) else $error("hold");
  AST_KEEP: assert property (serial_out_en |-> $stable(w)) else $error("keep");
  AST_END: assert property (latch_frame_n [*8] |-> !serial_out_en) else $error("end");
  AST_GO: assert property ($rose(serial_out_en) |-> !$past(latch_frame_n, 4))
    else $error("go");
  AST_EDGE: assert property (serial_out_en && $changed(serial_out) |-> !$past(serial_clk, 2))
    else $error("edge");
  cover property ($rose(serial_out_en));
  cover property ($changed(w));
  cover property ($rose(offset_loop_disable));
endmodule
`default_nettype wire

// *** verification/fgscp_host_model.sv ***
// host controller model for the serial port
`timescale 1ns/1ns
`default_nettype none
module fgscp_host_model (
  input wire logic ref_clk,
  input wire logic serial_out,
  output var logic latch_frame_n = 1'b1,
  output var logic serial_clk = 1'b0,
  output var logic serial_data = 1'b0
);
  // clock stands low between frames; nb=9 on a read lets bit 7 be sampled
  task automatic xfer(input logic wr, input logic [7:0] d, input int nb, output logic [7:0] q);
    latch_frame_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i <= nb; i++) begin
      if (!wr && i > 1) q[i-2] = serial_out;
      serial_clk <= 1'b0;
      serial_data <= (i == 0) ? wr : (wr ? d[i-1] : ~serial_data);
      repeat (4) @(posedge ref_clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    latch_frame_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    serial_clk <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// bench for the serial port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fgscp_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, offset_loop_disable = 1'b0;
  wire logic latch_frame_n, serial_clk, serial_data;
  logic serial_out, serial_out_en, signal_pass, preamp_gain_6db, vga_max_gain_sel;
  logic postamp_gain_sel, offset_loop_enable;
  logic [FREQ_W-1:0] corner_code;
  logic [31:0] seed = 32'h35F4850D;
  logic [7:0] wd, q;
  int miscompares = 0, check_count = 0;
  wire logic [7:0] w = {postamp_gain_sel, vga_max_gain_sel, preamp_gain_6db, corner_code};
  fgscp_port u_fgscp_port (.*);
  fgscp_host_model u_host (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #25 ref_clk = ~ref_clk;
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 14; k++) begin
      seed = xs(seed);
      wd = (k == 0) ? 8'hE0 : (k == 1) ? 8'hFF : seed[7:0];
      offset_loop_disable <= seed[8];
      u_host.xfer(1'b1, wd, 8, q);
      chk("word", wd, w);
      chk("flags", {6'h00, |wd[4:0], ~seed[8]}, {6'h00, signal_pass, offset_loop_enable});
      u_host.xfer(1'b0, 8'h00, 9, q);
      chk("read", wd, q);
      u_host.xfer(1'b1, ~wd, k % 8, q);
      chk("short", wd, w);
    end
    finish_test();
  end
endmodule
bind fgscp_port fgscp_port_assertions u_chk (.*);
`default_nettype wire
